// [dual_baud_pkg.sv]
// Constants, divisor tables and state types for the dual baud-rate divider
// Function
// - Variant 00 codes 0..15 select divisors 6336 down to 16.
// - Variant 02 codes 0..15 select divisors 3456 down to 9.
// - Variant 03 codes 0..15 select divisors 7523 down to 20.
// - Variant 04 uses the variant 02 divisors with a doubled input clock.
// - Variant 05 codes 0..15 select divisors 6144 down to 16.
// - Variant 06 codes 0..15 select divisors 3168 down to 8.
// - Uneven divisors keep each output phase within 50 percent plus minus 10.
// - Dividers count rising edges of the reference clock, not its level.
// - Receiver code loads into its latch while the receiver strobe is high.
// - Transmitter code loads while its strobe is high; channels are independent.
// - Each counter is 15 bits and divides by 2 up to 32767.
package dual_baud_pkg;

  localparam int CODE_W = 4;
  localparam int CNT_W = 15;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_VARIANTS = 6;
  localparam int NUM_CODES = 16;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  // Variant index: 0..5 stands for mask variants 00, 02, 03, 04, 05, 06
  localparam logic [CNT_W-1:0] DIV_TABLE [NUM_VARIANTS][NUM_CODES] = '{
    '{6336, 4224, 2880, 2355, 2112, 1056, 528, 264,
      176, 158, 132, 88, 66, 44, 33, 16},
    '{3456, 2304, 1571, 1285, 1152, 864, 576, 288,
      144, 96, 86, 72, 48, 36, 18, 9},
    '{7523, 5015, 3420, 2797, 2508, 1881, 1254, 627,
      313, 209, 188, 157, 104, 78, 39, 20},
    '{3456, 2304, 1571, 1285, 1152, 864, 576, 288,
      144, 96, 86, 72, 48, 36, 18, 9},
    '{6144, 4096, 2793, 2284, 2048, 1024, 512, 256,
      171, 154, 128, 85, 64, 43, 32, 16},
    '{3168, 2112, 1440, 1178, 1056, 792, 528, 264,
      132, 88, 66, 44, 33, 22, 17, 8}
  };

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic phase;
    logic out;
  } chan_type;

  localparam chan_type CHAN_RESET = '{cnt: 15'h0001, phase: 1'b0, out: 1'b0};

  typedef struct packed {
    logic refclk;
    logic rx_stb;
    logic tx_stb;
    logic [CODE_W-1:0] rx_code;
    logic [CODE_W-1:0] tx_code;
  } pin_type;

  // Index 0 is the receive channel, index 1 the transmit channel
  typedef struct packed {
    pin_type sync1;
    pin_type sync2;
    logic ref_prev;
    logic [1:0][CODE_W-1:0] code;
    chan_type [1:0] ch;
    logic [1:0] enable;
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } state_type;

endpackage

// [dual_baud_rate_divider.sv]
// Dual baud-rate divider with pin-strobed rate codes and an APB register port
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
module dual_baud_rate_divider #(
  parameter int VARIANT = 0
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // Reference clock and rate select pins
  input wire logic REFERENCE_CLOCK_IN,
  input wire logic RECEIVER_CODE_STROBE,
  input wire logic [dual_baud_pkg::CODE_W-1:0] RECEIVER_RATE_CODE,
  input wire logic TRANSMITTER_CODE_STROBE,
  input wire logic [dual_baud_pkg::CODE_W-1:0] TRANSMITTER_RATE_CODE,
  // Baud clocks
  output logic RECEIVE_CLOCK_OUT,
  output logic TRANSMIT_CLOCK_OUT,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [dual_baud_pkg::ADDR_W-1:0] PADDR,
  input wire logic [dual_baud_pkg::DATA_W-1:0] PWDATA,
  output logic PREADY,
  output logic [dual_baud_pkg::DATA_W-1:0] PRDATA,
  output logic PSLVERR
);
  import dual_baud_pkg::*;

  state_type q;
  state_type d;
  logic ref_edge;
  logic [1:0][CNT_W-1:0] div_w;
  logic [1:0][CNT_W-1:0] lo_w;
  logic [1:0][CNT_W-1:0] hi_w;

  // The reference pin is sampled, so it must stay well under half of CLOCK
  assign ref_edge = q.sync2.refclk & ~q.ref_prev;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_lookup
      // Fixed mask table chosen at build time
      assign div_w[gi] = DIV_TABLE[VARIANT][q.code[gi]];
      assign lo_w[gi] = div_w[gi] >> 1;
      assign hi_w[gi] = div_w[gi] - lo_w[gi];
    end
  endgenerate

  always_comb begin
    d = q;
    d.sync1 = '{refclk: REFERENCE_CLOCK_IN, rx_stb: RECEIVER_CODE_STROBE,
                tx_stb: TRANSMITTER_CODE_STROBE,
                rx_code: RECEIVER_RATE_CODE,
                tx_code: TRANSMITTER_RATE_CODE};
    d.sync2 = q.sync1;
    d.ref_prev = q.sync2.refclk;
    // Level-sensitive latch: a tied-high strobe lets the code follow the pins
    if (q.sync2.rx_stb) begin
      d.code[0] = q.sync2.rx_code;
    end
    if (q.sync2.tx_stb) begin
      d.code[1] = q.sync2.tx_code;
    end
    for (int i = 0; i < 2; i++) begin
      if (!q.enable[i]) begin
        d.ch[i] = CHAN_RESET;
      end else if (ref_edge) begin
        if (q.ch[i].cnt <= 15'h0001) begin
          // Reload only here, so a new code never cuts a phase short
          d.ch[i].out = ~q.ch[i].out;
          d.ch[i].phase = ~q.ch[i].phase;
          d.ch[i].cnt = q.ch[i].phase ? hi_w[i] : lo_w[i];
        end else begin
          d.ch[i].cnt = q.ch[i].cnt - 15'h0001;
        end
      end
    end
    // Registered answer: ready in the first access cycle, zero wait states
    d.pready = PSEL & ~PENABLE;
    d.pslverr = 1'b0;
    d.prdata = '0;
    if (PSEL && !PENABLE) begin
      if (PADDR == CTRL_OFS) begin
        d.prdata = {30'h0, q.enable};
      end else if (PADDR == STATUS_OFS) begin
        d.prdata = {22'h0, q.ch[1].out, q.ch[0].out, q.code[1], q.code[0]};
      end else begin
        d.pslverr = 1'b1;
      end
    end
    if (PSEL && PENABLE && q.pready && PWRITE && PADDR == CTRL_OFS) begin
      d.enable = PWDATA[1:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      q <= '0;
      q.ch <= {CHAN_RESET, CHAN_RESET};
      q.enable <= CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  assign RECEIVE_CLOCK_OUT = q.ch[0].out;
  assign TRANSMIT_CLOCK_OUT = q.ch[1].out;
  assign PREADY = q.pready;
  assign PRDATA = q.prdata;
  assign PSLVERR = q.pslverr;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  low_half_load_a: assert property (
    ref_edge && q.enable[0] && d.enable[0] && q.ch[0].cnt <= 15'h0001
      && !q.ch[0].phase
    |=> q.ch[0].cnt == (DIV_TABLE[VARIANT][$past(q.code[0])] >> 1))
    else $error("receive channel loaded wrong first half");

  duty_band_a: assert property (
    q.enable[1] |-> (32'(lo_w[1]) * 5 >= 32'(div_w[1]) * 2)
      && (32'(hi_w[1]) * 5 <= 32'(div_w[1]) * 3))
    else $error("transmit halves outside duty band");

  edge_only_a: assert property (
    !ref_edge && q.enable[0] && d.enable[0] |=> $stable(q.ch[0].cnt))
    else $error("counter moved without a reference edge");

  rx_latch_a: assert property (
    q.sync2.rx_stb |=> q.code[0] == $past(q.sync2.rx_code))
    else $error("receiver code not latched under strobe");

  tx_latch_hold_a: assert property (
    !q.sync2.tx_stb |=> $stable(q.code[1]))
    else $error("transmitter code changed without strobe");

  counter_range_a: assert property (
    q.ch[0].cnt != 15'h0000 && q.ch[1].cnt != 15'h0000 && div_w[0] >= 15'h0002)
    else $error("counter or divisor out of range");

  high_half_load_a: assert property (
    ref_edge && q.enable[1] && d.enable[1] && q.ch[1].cnt <= 15'h0001
      && q.ch[1].phase
    |=> q.ch[1].cnt == $past(hi_w[1]) && !q.ch[1].phase)
    else $error("transmit channel loaded wrong second half");

  no_runt_a: assert property (
    $changed(q.ch[0].out) && $past(q.enable[0])
    |-> $past(ref_edge) && $past(q.ch[0].cnt) <= 15'h0001)
    else $error("receive output toggled before reload");

  tx_no_runt_a: assert property (
    $changed(q.ch[1].out) && $past(q.enable[1])
    |-> $past(ref_edge) && $past(q.ch[1].cnt) <= 15'h0001)
    else $error("transmit output toggled before reload");

  rx_high_half_a: assert property (
    ref_edge && q.enable[0] && d.enable[0] && q.ch[0].cnt <= 15'h0001
      && q.ch[0].phase
    |=> q.ch[0].cnt == DIV_TABLE[VARIANT][$past(q.code[0])]
      - (DIV_TABLE[VARIANT][$past(q.code[0])] >> 1) && !q.ch[0].phase)
    else $error("receive channel loaded wrong second half");

  tx_low_half_a: assert property (
    ref_edge && q.enable[1] && d.enable[1] && q.ch[1].cnt <= 15'h0001
      && !q.ch[1].phase
    |=> q.ch[1].cnt == (DIV_TABLE[VARIANT][$past(q.code[1])] >> 1)
      && q.ch[1].phase && q.ch[1].out)
    else $error("transmit channel loaded wrong first half");

  tx_edge_only_a: assert property (
    !ref_edge && q.enable[1] && d.enable[1] |=> $stable(q.ch[1].cnt))
    else $error("transmit counter moved without a reference edge");

  rx_count_down_a: assert property (
    ref_edge && q.enable[0] && d.enable[0] && q.ch[0].cnt > 15'h0001
    |=> q.ch[0].cnt == $past(q.ch[0].cnt) - 15'h0001
      && $stable(q.ch[0].out))
    else $error("receive counter did not step down by one");

  rx_duty_band_a: assert property (
    q.enable[0] |-> (32'(lo_w[0]) * 5 >= 32'(div_w[0]) * 2)
      && (32'(hi_w[0]) * 5 <= 32'(div_w[0]) * 3))
    else $error("receive halves outside duty band");

  rx_latch_hold_a: assert property (
    !q.sync2.rx_stb |=> $stable(q.code[0]))
    else $error("receiver code changed without strobe");

  tx_latch_a: assert property (
    q.sync2.tx_stb |=> q.code[1] == $past(q.sync2.tx_code))
    else $error("transmitter code not latched under strobe");

  // A disabled channel restarts cleanly from phase 0 when enabled again
  rx_off_quiet_a: assert property (
    !q.enable[0] |=> !q.ch[0].out && q.ch[0].cnt == 15'h0001)
    else $error("disabled receive channel not held at rest");

  tx_off_quiet_a: assert property (
    !q.enable[1] |=> !q.ch[1].out && q.ch[1].cnt == 15'h0001)
    else $error("disabled transmit channel not held at rest");

  // Bus answers come in the cycle after setup, with zero wait states
  apb_ready_a: assert property (
    PSEL && !PENABLE |=> q.pready)
    else $error("no ready in the first access cycle");

  apb_idle_ready_a: assert property (
    !(PSEL && !PENABLE) |=> !q.pready)
    else $error("ready raised without a setup cycle");

  apb_error_a: assert property (
    PSEL && !PENABLE && PADDR != CTRL_OFS && PADDR != STATUS_OFS
    |=> q.pslverr && q.prdata == 32'h0)
    else $error("unmapped access not refused");

  apb_quiet_a: assert property (
    !q.pready |-> !q.pslverr && q.prdata == 32'h0)
    else $error("read data or error shown outside ready");

  status_read_a: assert property (
    PSEL && !PENABLE && PADDR == STATUS_OFS
    |=> q.prdata[7:0] == {$past(q.code[1]), $past(q.code[0])}
      && q.prdata[9:8] == {$past(q.ch[1].out), $past(q.ch[0].out)})
    else $error("status read does not show codes and outputs");

  ctrl_write_a: assert property (
    PSEL && PENABLE && q.pready && PWRITE && PADDR == CTRL_OFS
    |=> q.enable == 2'($past(PWDATA)))
    else $error("control write did not land");

  enable_hold_a: assert property (
    !(PSEL && PENABLE && q.pready && PWRITE && PADDR == CTRL_OFS)
    |=> $stable(q.enable))
    else $error("enable bits changed without a control write");

endmodule

// [ref_source.sv]
// Reference clock source standing in for the far-side oscillator
`timescale 1ns/1ps
module ref_source (
  // Clock
  input wire logic clock,
  // Control and reference output
  input wire logic run,
  output logic ref_out
);
  logic [1:0] cnt_q;

  // Made from the system clock so each reference period is four cycles
  always_ff @(posedge clock) begin
    if (!run) begin
      cnt_q <= 2'h0;
      ref_out <= 1'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      ref_out <= cnt_q[1];
    end
  end
endmodule

// [dual_baud_rate_divider_bench.sv]
// Self-checking bench for the dual baud-rate divider
`timescale 1ns/1ps
module dual_baud_rate_divider_bench;
  import dual_baud_pkg::*;
  logic clock, resetn, run, ref_clk, rx_stb, tx_stb, rx_o, tx_o, err;
  logic psel, penable, pwrite, pready, pslverr;
  logic [CODE_W-1:0] rx_code, tx_code;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  int num_errors, check_count, hi, per;

  ref_source src_u (.clock(clock), .run(run), .ref_out(ref_clk));
  dual_baud_rate_divider #(.VARIANT(0)) dut_u (.CLOCK(clock),
    .RESETN(resetn), .REFERENCE_CLOCK_IN(ref_clk),
    .RECEIVER_CODE_STROBE(rx_stb), .RECEIVER_RATE_CODE(rx_code),
    .TRANSMITTER_CODE_STROBE(tx_stb), .TRANSMITTER_RATE_CODE(tx_code),
    .RECEIVE_CLOCK_OUT(rx_o), .TRANSMIT_CLOCK_OUT(tx_o), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr));

  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  task chk(input string name, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task wrap_up;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'h1;
    // This wait ends once pready is seen high; the watchdog catches a hang
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Finds a rising edge, then counts high and total cycles of one period
  task meas(input logic tx);
    logic p, o;
    int n;
    p = 1'h1;
    for (n = 0; n < 30000; n++) begin
      @(posedge clock);
      o = tx ? tx_o : rx_o;
      if (o === 1'h1 && p === 1'h0) break;
      p = o;
    end
    hi = 0;
    per = 0;
    p = 1'h1;
    for (n = 0; n < 30000; n++) begin
      @(posedge clock);
      o = tx ? tx_o : rx_o;
      per++;
      if (o === 1'h1) hi++;
      if (o === 1'h1 && p === 1'h0) break;
      p = o;
    end
  endtask

  task test_rates;
    @(posedge clock);
    rx_code <= 4'hf;
    tx_code <= 4'he;
    repeat (2) @(posedge clock);
    rx_stb <= 1'h1;
    tx_stb <= 1'h1;
    repeat (3) @(posedge clock);
    rx_stb <= 1'h0;
    tx_stb <= 1'h0;
    repeat (2) @(posedge clock);
    apb(1'h0, STATUS_OFS, 32'h0);
    chk("codes", {24'h0, rd[7:0]}, 32'hef);
    apb(1'h0, 8'h08, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    meas(1'h0);
    chk("rx high", hi, 32'h20);
    chk("rx period", per, 32'h40);
    meas(1'h1);
    chk("tx high", hi, 32'h40);
    chk("tx period", per, 32'h84);
    $display("test rates done");
  endtask

  task test_disable;
    apb(1'h1, CTRL_OFS, 32'h1);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk("ctrl readback", rd, 32'h1);
    repeat (2) @(posedge clock);
    hi = 0;
    repeat (300) begin
      @(posedge clock);
      if (tx_o !== 1'h0) hi++;
    end
    chk("tx stopped", hi, 32'h0);
    meas(1'h0);
    chk("rx alone", per, 32'h40);
    apb(1'h1, CTRL_OFS, 32'h3);
    $display("test disable done");
  endtask

  initial begin
    resetn = 1'h0;
    run = 1'h0;
    rx_stb = 1'h0;
    tx_stb = 1'h0;
    rx_code = 4'h0;
    tx_code = 4'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    num_errors = 0;
    check_count = 0;
    repeat (12) @(posedge clock);
    resetn <= 1'h1;
    run <= 1'h1;
    test_rates;
    test_disable;
    wrap_up;
  end

  // Slowest wait is one old-code half period of about 13k cycles
  initial begin
    repeat (60000) @(posedge clock);
    num_errors++;
    wrap_up;
  end
endmodule
